// >>> hdl/sau_pkg.sv
// Purpose: Shared constants and operation codes for the saturating arithmetic unit.
// Assumes: 16-bit words, double words as an upper/lower pair of words.
// Notes:   Used by the datapath top and by the bench.

package sau_pkg;

    // ****************************************************************
    // Widths and fixed values
    // ****************************************************************
    localparam int          WORD_W         = 16;
    localparam int          DWORD_W        = 32;
    localparam logic [15:0] WORD_RESET     = 16'h0000;
    localparam logic [15:0] WORD_MAX       = 16'h7fff;
    localparam logic [15:0] WORD_MIN       = 16'h8000;
    localparam logic [15:0] WORD_MINUS_ONE = 16'hffff;
    localparam logic [31:0] DWORD_MAX      = 32'h7fff_ffff;
    localparam logic [31:0] DWORD_MIN      = 32'h8000_0000;
    localparam int          LATENCY_CYCLES = 1;

    // ****************************************************************
    // Operation select
    // ****************************************************************
    typedef enum logic [2:0] {
        OP_SUB,
        OP_MUL,
        OP_DIV,
        OP_DADD,
        OP_DSUB
    } arith_op_e;

endpackage : sau_pkg

// >>> hdl/sat_addsub.sv
// Purpose: Signed add or subtract of W-bit values with clamping at the signed limits.
// Assumes: Purely combinational; the caller registers the result.
// Notes:   One extra bit of headroom makes overflow detection exact.

`timescale 1ns/1ps

module sat_addsub #(
    parameter int W = 32
) (
    input  wire logic [W-1:0] i_a,        // first operand
    input  wire logic [W-1:0] i_b,        // second operand
    input  wire logic         i_subtract, // high: a minus b
    output logic      [W-1:0] o_result,   // clamped result
    output logic              o_overflow  // result was clamped
);

    localparam logic [W-1:0] SAT_MAX = {1'b0, {(W-1){1'b1}}};
    localparam logic [W-1:0] SAT_MIN = {1'b1, {(W-1){1'b0}}};

    logic [W:0] wide;

    assign wide       = i_subtract ? ({i_a[W-1], i_a} - {i_b[W-1], i_b})
                                   : ({i_a[W-1], i_a} + {i_b[W-1], i_b});
    // The two top bits disagree exactly when the true result left the range.
    assign o_overflow = wide[W] ^ wide[W-1];
    assign o_result   = !o_overflow ? wide[W-1:0] : (wide[W] ? SAT_MIN : SAT_MAX);

endmodule : sat_addsub

// >>> hdl/saturating_arith_unit.sv
// Purpose: Arithmetic datapath of the ladder instruction executor.
// Assumes: Operands and controls come from the sequencer on the same clock.
// Notes:   Results appear one cycle after an enabled request, with write strobes.
//
// What this block does
// - Work only while enabled; otherwise write nothing and hold the indicator low.
// - The word subtraction writes the signed first operand minus the second.
// - A word difference above the positive limit writes 32767 and raises the indicator.
// - A word difference below the negative limit writes -32768 and raises the indicator.
// - For saturating subtraction and double addition the indicator is high only on clamping.
// - Multiplication stores the signed 32-bit product, upper half in the higher word.
// - Division by non-zero writes quotient low, remainder high and raises the indicator.
// - A zero divisor skips the division, keeps the indicator low and sets the error flag.
// - The error flag stays set until the program clears it explicitly.
// - With the index register as destination only the quotient is stored.
// - -32768 divided by -1 gives quotient -32768 and remainder 0 with no error.
// - Double addition adds two signed 32-bit pairs and stores the sum in the pair.
// - A double sum above the positive 32-bit limit stores the positive limit.
// - A double sum below the negative 32-bit limit stores the negative limit.

`timescale 1ns/1ps

module saturating_arith_unit (
    input  wire logic              i_clk,              // 20 MHz clock
    input  wire logic              i_rstn,             // synchronous reset, active low
    input  wire logic              i_enable,           // execution input of the instruction
    input  wire sau_pkg::arith_op_e i_op,              // operation select
    input  wire logic [15:0]       i_a_lo,             // operand A, lower word
    input  wire logic [15:0]       i_a_hi,             // operand A, upper word
    input  wire logic [15:0]       i_b_lo,             // operand B, lower word
    input  wire logic [15:0]       i_b_hi,             // operand B, upper word
    input  wire logic              i_dest_is_index,    // destination is the index register
    input  wire logic              i_error_clear,      // program resets the error flag
    output logic                   o_out,              // output indicator
    output logic [15:0]            o_res_lo,           // result for destination word
    output logic [15:0]            o_res_hi,           // result for next-higher word
    output logic                   o_write_lo,         // write destination word
    output logic                   o_write_hi,         // write next-higher word
    output logic                   o_done,             // one enabled operation completed
    output logic                   o_instruction_error_flag // sticky instruction error
);

    // ****************************************************************
    // Arithmetic
    // ****************************************************************
    logic [15:0]        sub_res;
    logic               sub_ovf;
    logic [31:0]        dbl_res;
    logic               dbl_ovf;
    logic signed [31:0] product;
    logic signed [16:0] div_num;
    logic signed [16:0] div_den;
    logic signed [16:0] quo_wide;
    logic signed [16:0] rem_wide;
    logic               div_zero;
    logic               div_special;

    sat_addsub #(.W(sau_pkg::WORD_W)) u_sub16 (
        .i_a        (i_a_lo),
        .i_b        (i_b_lo),
        .i_subtract (1'b1),
        .o_result   (sub_res),
        .o_overflow (sub_ovf)
    );

    sat_addsub #(.W(sau_pkg::DWORD_W)) u_dbl (
        .i_a        ({i_a_hi, i_a_lo}),
        .i_b        ({i_b_hi, i_b_lo}),
        .i_subtract (i_op == sau_pkg::OP_DSUB),
        .o_result   (dbl_res),
        .o_overflow (dbl_ovf)
    );

    assign product     = $signed(i_a_lo) * $signed(i_b_lo);
    assign div_zero    = (i_b_lo == sau_pkg::WORD_RESET);
    assign div_special = (i_a_lo == sau_pkg::WORD_MIN) && (i_b_lo == sau_pkg::WORD_MINUS_ONE);
    assign div_num     = $signed({i_a_lo[15], i_a_lo});
    // A zero divisor is swapped for one so the divider never sees it; the result is unused.
    assign div_den     = div_zero ? 17'sh0_0001 : $signed({i_b_lo[15], i_b_lo});
    assign quo_wide    = div_num / div_den;
    assign rem_wide    = div_num % div_den;

    // ****************************************************************
    // Next values
    // ****************************************************************
    logic        indicator, next_indicator;
    logic [15:0] res_lo, next_res_lo;
    logic [15:0] res_hi, next_res_hi;
    logic        write_lo, next_write_lo;
    logic        write_hi, next_write_hi;
    logic        done, next_done;
    logic        instruction_error_flag, next_instruction_error_flag;

    always_comb begin
        next_indicator              = 1'b0;
        next_res_lo                 = res_lo;
        next_res_hi                 = res_hi;
        next_write_lo               = 1'b0;
        next_write_hi               = 1'b0;
        next_done                   = 1'b0;
        next_instruction_error_flag = instruction_error_flag;
        if (i_error_clear) begin
            next_instruction_error_flag = 1'b0;
        end
        if (i_enable) begin
            next_done = 1'b1;
            case (i_op)
                sau_pkg::OP_SUB: begin
                    next_res_lo   = sub_res;
                    next_write_lo = 1'b1;
                    next_indicator = sub_ovf;
                end
                sau_pkg::OP_MUL: begin
                    next_res_lo   = product[15:0];
                    next_res_hi   = product[31:16];
                    next_write_lo = 1'b1;
                    next_write_hi = 1'b1;
                    next_indicator = 1'b1;
                end
                sau_pkg::OP_DIV: begin
                    if (div_zero) begin
                        // error, no division; set wins over a same-cycle clear
                        next_instruction_error_flag = 1'b1;
                    end else begin
                        next_res_lo   = quo_wide[15:0];
                        next_res_hi   = rem_wide[15:0];
                        next_write_lo = 1'b1;
                        next_indicator = 1'b1;
                        if (div_special) begin
                            next_res_lo = sau_pkg::WORD_MIN;
                            next_res_hi = sau_pkg::WORD_RESET;
                        end
                        next_write_hi = !i_dest_is_index;
                    end
                end
                sau_pkg::OP_DADD, sau_pkg::OP_DSUB: begin
                    next_res_lo   = dbl_res[15:0];
                    next_res_hi   = dbl_res[31:16];
                    next_write_lo = 1'b1;
                    next_write_hi = 1'b1;
                    next_indicator = dbl_ovf;
                end
                default: begin
                    next_done = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            indicator              <= 1'b0;
            res_lo                 <= sau_pkg::WORD_RESET;
            res_hi                 <= sau_pkg::WORD_RESET;
            write_lo               <= 1'b0;
            write_hi               <= 1'b0;
            done                   <= 1'b0;
            instruction_error_flag <= 1'b0;
        end else begin
            indicator              <= next_indicator;
            res_lo                 <= next_res_lo;
            res_hi                 <= next_res_hi;
            write_lo               <= next_write_lo;
            write_hi               <= next_write_hi;
            done                   <= next_done;
            instruction_error_flag <= next_instruction_error_flag;
        end
    end

    assign o_out                    = indicator;
    assign o_res_lo                 = res_lo;
    assign o_res_hi                 = res_hi;
    assign o_write_lo               = write_lo;
    assign o_write_hi               = write_hi;
    assign o_done                   = done;
    assign o_instruction_error_flag = instruction_error_flag;

    // ****************************************************************
    // Checks
    // ****************************************************************
    logic signed [16:0] chk_diff;
    logic signed [32:0] chk_dsum;
    logic               live;

    assign chk_diff = $signed({i_a_lo[15], i_a_lo}) - $signed({i_b_lo[15], i_b_lo});
    assign chk_dsum = (i_op == sau_pkg::OP_DSUB)
                    ? $signed({i_a_hi[15], i_a_hi, i_a_lo}) - $signed({i_b_hi[15], i_b_hi, i_b_lo})
                    : $signed({i_a_hi[15], i_a_hi, i_a_lo}) + $signed({i_b_hi[15], i_b_hi, i_b_lo});
    assign live     = i_rstn && i_enable;

    a_idle_no_write: assert property (@(posedge i_clk) disable iff (!i_rstn)
        i_rstn && !i_enable |=> !o_out && !o_write_lo && !o_write_hi && !o_done)
        else $error("write or indicator without enable");

    a_sub_in_range: assert property (@(posedge i_clk) disable iff (!i_rstn)
        live && i_op == sau_pkg::OP_SUB && chk_diff <= 17'sh0_7fff && chk_diff >= 17'sh1_8000
        |=> o_write_lo && !o_out && o_res_lo == $past(chk_diff[15:0]))
        else $error("wrong unclamped difference");

    a_sub_clamp_hi: assert property (@(posedge i_clk) disable iff (!i_rstn)
        live && i_op == sau_pkg::OP_SUB && chk_diff > 17'sh0_7fff
        |=> o_out && o_res_lo == sau_pkg::WORD_MAX)
        else $error("positive word clamp missing");

    a_sub_clamp_lo: assert property (@(posedge i_clk) disable iff (!i_rstn)
        live && i_op == sau_pkg::OP_SUB && chk_diff < 17'sh1_8000
        |=> o_out && o_res_lo == sau_pkg::WORD_MIN)
        else $error("negative word clamp missing");

    a_mul_halves: assert property (@(posedge i_clk) disable iff (!i_rstn)
        live && i_op == sau_pkg::OP_MUL |=> o_out && o_write_hi
        && $signed({o_res_hi, o_res_lo}) == $signed($past(i_a_lo)) * $signed($past(i_b_lo)))
        else $error("product wrong");

    a_div_by_zero: assert property (@(posedge i_clk) disable iff (!i_rstn)
        live && i_op == sau_pkg::OP_DIV && i_b_lo == 16'h0000
        |=> !o_out && !o_write_lo && !o_write_hi && o_instruction_error_flag)
        else $error("zero divisor handled wrongly");

    a_err_sticky: assert property (@(posedge i_clk) disable iff (!i_rstn)
        o_instruction_error_flag && !i_error_clear |=> o_instruction_error_flag [*1])
        else $error("error flag dropped without clear");

    a_div_index: assert property (@(posedge i_clk) disable iff (!i_rstn)
        live && i_op == sau_pkg::OP_DIV && i_b_lo != 16'h0000
        |=> o_out && o_write_lo && (o_write_hi == !$past(i_dest_is_index)))
        else $error("division write strobes wrong");

    a_div_special: assert property (@(posedge i_clk) disable iff (!i_rstn)
        live && i_op == sau_pkg::OP_DIV && i_a_lo == 16'h8000 && i_b_lo == 16'hffff
        && !i_error_clear && !o_instruction_error_flag
        |=> o_res_lo == 16'h8000 && o_res_hi == 16'h0000 && !o_instruction_error_flag)
        else $error("most negative by minus one wrong");

    a_dbl_clamp: assert property (@(posedge i_clk) disable iff (!i_rstn)
        live && (i_op == sau_pkg::OP_DADD || i_op == sau_pkg::OP_DSUB)
        |=> o_write_lo && o_write_hi && (o_out == ($past(chk_dsum[32]) != $past(chk_dsum[31])))
        && {o_res_hi, o_res_lo} == (!o_out ? $past(chk_dsum[31:0])
           : ($past(chk_dsum[32]) ? sau_pkg::DWORD_MIN : sau_pkg::DWORD_MAX)))
        else $error("double result or clamp wrong");

    a_one_cycle: assert property (@(posedge i_clk) disable iff (!i_rstn)
        live && i_op == sau_pkg::OP_MUL ##1 !i_enable |-> o_done ##1 !o_done)
        else $error("completion not single cycle");

endmodule : saturating_arith_unit

// >>> tb/seq_writeback_model.sv
// Purpose: Writeback model of the sequencer: keeps destination words C and C+1.
// Assumes: Strobes and result words arrive registered from the unit.
// Notes:   An unstrobed word keeps its value, as the real register file does.

`timescale 1ns/1ps

module seq_writeback_model (
    input  wire logic        i_clk,      // clock
    input  wire logic        i_rstn,     // synchronous reset, active low
    input  wire logic        i_write_lo, // write word C
    input  wire logic        i_write_hi, // write word C+1
    input  wire logic [15:0] i_res_lo,   // value for C
    input  wire logic [15:0] i_res_hi,   // value for C+1
    output logic      [15:0] o_word_c,   // stored word C
    output logic      [15:0] o_word_c1   // stored word C+1
);
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_word_c  <= 16'h0000;
            o_word_c1 <= 16'h0000;
        end else begin
            if (i_write_lo) begin
                o_word_c <= i_res_lo;
            end
            if (i_write_hi) begin
                o_word_c1 <= i_res_hi;
            end
        end
    end
endmodule : seq_writeback_model

// >>> tb/saturating_arith_unit_tb.sv
// Purpose: Self-checking bench of the saturating arithmetic unit.
// Assumes: Results come exactly one cycle after an enabled request.
// Notes:   Expected values are worked out by hand from signed arithmetic.

`timescale 1ns/1ps

module saturating_arith_unit_tb;
    logic               i_clk, i_rstn, i_enable, i_dest_is_index, i_error_clear;
    sau_pkg::arith_op_e i_op;
    logic        [15:0] i_a_lo, i_a_hi, i_b_lo, i_b_hi, o_res_lo, o_res_hi, word_c, word_c1;
    logic               o_out, o_write_lo, o_write_hi, o_done, o_instruction_error_flag;
    int                 n_errors, num_checks;

    saturating_arith_unit dut_u (.i_clk(i_clk), .i_rstn(i_rstn), .i_enable(i_enable),
        .i_op(i_op), .i_a_lo(i_a_lo), .i_a_hi(i_a_hi), .i_b_lo(i_b_lo), .i_b_hi(i_b_hi),
        .i_dest_is_index(i_dest_is_index), .i_error_clear(i_error_clear), .o_out(o_out),
        .o_res_lo(o_res_lo), .o_res_hi(o_res_hi), .o_write_lo(o_write_lo),
        .o_write_hi(o_write_hi), .o_done(o_done),
        .o_instruction_error_flag(o_instruction_error_flag));
    seq_writeback_model wb_u (.i_clk(i_clk), .i_rstn(i_rstn), .i_write_lo(o_write_lo),
        .i_write_hi(o_write_hi), .i_res_lo(o_res_lo), .i_res_hi(o_res_hi),
        .o_word_c(word_c), .o_word_c1(word_c1));

    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s: got %h, expected %h", $time, what, seen, exp);
        end
    endtask : check

    // Drives one request for one cycle, then samples just after the answering edge.
    task automatic issue(input sau_pkg::arith_op_e op, input logic [31:0] a, input logic [31:0] b,
                         input logic idx, input logic en, input logic clr);
        @(posedge i_clk);
        i_enable <= en;
        i_op <= op;
        {i_a_hi, i_a_lo} <= a;
        {i_b_hi, i_b_lo} <= b;
        i_dest_is_index <= idx;
        i_error_clear <= clr;
        repeat (sau_pkg::LATENCY_CYCLES) @(posedge i_clk);
        i_enable <= 1'b0;
        i_error_clear <= 1'b0;
        #1;
    endtask : issue

    task automatic run(input sau_pkg::arith_op_e op, input logic [31:0] a, input logic [31:0] b,
                       input logic idx, input logic [31:0] e, input logic e_out,
                       input logic e_wlo, input logic e_whi);
        logic [15:0] c0;
        logic [15:0] c1;
        c0 = word_c;
        c1 = word_c1;
        issue(op, a, b, idx, 1'b1, 1'b0);
        check(o_done, 1'b1, "done");
        check(o_out, e_out, "indicator");
        check({o_write_hi, o_write_lo}, {e_whi, e_wlo}, "strobes");
        @(posedge i_clk);
        #1;
        check(word_c, e_wlo ? e[15:0] : c0, "word C");
        check(word_c1, e_whi ? e[31:16] : c1, "word C+1");
    endtask : run

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic sc_sub();
        run(sau_pkg::OP_SUB, 32'h1234_3a98, 32'h5555_09c4, 0, 32'h0000_30d4, 0, 1, 0);
        run(sau_pkg::OP_SUB, 32'h0000_86e8, 32'h0000_09c4, 0, 32'h0000_8000, 1, 1, 0);
        run(sau_pkg::OP_SUB, 32'h0000_7fbc, 32'h0000_fc18, 0, 32'h0000_7fff, 1, 1, 0);
        run(sau_pkg::OP_SUB, 32'h0000_7fff, 32'h0000_0000, 0, 32'h0000_7fff, 0, 1, 0);
        run(sau_pkg::OP_SUB, 32'h0000_8000, 32'h0000_0000, 0, 32'h0000_8000, 0, 1, 0);
    endtask : sc_sub

    task automatic sc_mul();
        run(sau_pkg::OP_MUL, 32'h0000_05dc, 32'h0000_0014, 0, 32'h0000_7530, 1, 1, 1);
        run(sau_pkg::OP_MUL, 32'h0000_fffe, 32'h0000_0003, 0, 32'hffff_fffa, 1, 1, 1);
        run(sau_pkg::OP_MUL, 32'h0000_8000, 32'h0000_8000, 0, 32'h4000_0000, 1, 1, 1);
    endtask : sc_mul

    task automatic sc_div();
        run(sau_pkg::OP_DIV, 32'h0000_0b4e, 32'h0000_0145, 0, 32'h0126_0008, 1, 1, 1);
        run(sau_pkg::OP_DIV, 32'h0000_fff9, 32'h0000_0002, 0, 32'hffff_fffd, 1, 1, 1);
        run(sau_pkg::OP_DIV, 32'h0000_0b4e, 32'h0000_0145, 1, 32'h0000_0008, 1, 1, 0);
        run(sau_pkg::OP_DIV, 32'h0000_8000, 32'h0000_ffff, 0, 32'h0000_8000, 1, 1, 1);
        check(o_instruction_error_flag, 1'b0, "no error on limit divide");
    endtask : sc_div

    task automatic sc_flag();
        run(sau_pkg::OP_DIV, 32'h0000_0064, 32'h0000_0000, 0, 32'h0000_0000, 0, 0, 0);
        check(o_instruction_error_flag, 1'b1, "flag set");
        run(sau_pkg::OP_SUB, 32'h0000_0005, 32'h0000_0001, 0, 32'h0000_0004, 0, 1, 0);
        check(o_instruction_error_flag, 1'b1, "flag sticky");
        // The program's explicit reset of the flag loses to a new set in the same cycle.
        issue(sau_pkg::OP_DIV, 32'h0000_0001, 32'h0000_0000, 0, 1'b1, 1'b1);
        check(o_instruction_error_flag, 1'b1, "set beats clear");
        issue(sau_pkg::OP_SUB, 32'h0000_0000, 32'h0000_0000, 0, 1'b0, 1'b1);
        check(o_instruction_error_flag, 1'b0, "flag cleared");
    endtask : sc_flag

    task automatic sc_dadd();
        run(sau_pkg::OP_DADD, 32'h0004_93e0, 32'h0001_86a0, 0, 32'h0006_1a80, 0, 1, 1);
        run(sau_pkg::OP_DADD, 32'h0000_ffff, 32'h0000_0001, 0, 32'h0001_0000, 0, 1, 1);
        run(sau_pkg::OP_DADD, 32'h7fff_ffff, 32'h0000_0001, 0, 32'h7fff_ffff, 1, 1, 1);
        run(sau_pkg::OP_DADD, 32'h8000_0000, 32'hffff_ffff, 0, 32'h8000_0000, 1, 1, 1);
    endtask : sc_dadd

    task automatic sc_dsub();
        run(sau_pkg::OP_DSUB, 32'h0018_1be0, 32'h0001_3880, 0, 32'h0016_e360, 0, 1, 1);
        run(sau_pkg::OP_DSUB, 32'h0001_0000, 32'h0000_0001, 0, 32'h0000_ffff, 0, 1, 1);
        run(sau_pkg::OP_DSUB, 32'h8000_0000, 32'h0000_0001, 0, 32'h8000_0000, 1, 1, 1);
        run(sau_pkg::OP_DSUB, 32'h7fff_ffff, 32'hffff_ffff, 0, 32'h7fff_ffff, 1, 1, 1);
    endtask : sc_dsub

    // An overflowing request with enable low, then an unknown operation code.
    task automatic sc_idle();
        logic [15:0] held;
        held = o_res_lo;
        issue(sau_pkg::OP_SUB, 32'h0000_8000, 32'h0000_0001, 0, 1'b0, 1'b0);
        check({o_done, o_out, o_write_hi, o_write_lo}, 4'h0, "idle pulses");
        check(o_res_lo, held, "idle result held");
        issue(sau_pkg::arith_op_e'(3'h7), 32'h0000_0001, 32'h0000_0001, 0, 1'b1, 1'b0);
        check({o_done, o_out, o_write_hi, o_write_lo}, 4'h0, "bad code ignored");
    endtask : sc_idle

    task automatic test_done();
        $display("checks %0d, errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done

    initial begin
        repeat (5000) @(posedge i_clk);
        n_errors++;
        test_done();
    end

    initial begin
        {i_rstn, i_enable, i_dest_is_index, i_error_clear} = 4'h0;
        i_op = sau_pkg::OP_SUB;
        {i_a_lo, i_a_hi, i_b_lo, i_b_hi} = 64'h0000_0000_0000_0000;
        n_errors = 0;
        num_checks = 0;
        repeat (20) @(posedge i_clk);
        i_rstn <= 1'b1;
        #1;
        check({o_res_hi, o_res_lo}, 32'h0000_0000, "reset results");
        sc_sub();
        sc_mul();
        sc_div();
        sc_flag();
        sc_dadd();
        sc_dsub();
        sc_idle();
        test_done();
    end
endmodule : saturating_arith_unit_tb
